// file: rtl/psram_device.sv
// Purpose: device end of the ddr psram link, word array on a core port
// Assumes: link pins synchronous to clk; core_rdata held from one cycle
//          after core_re until the next core_re
// Notes:   bus clock edges are found by comparing with last sample
`timescale 1ns/1ps

// Functional notes
// - one word per bus cycle, two bytes
// - host frames: select, six bytes, latency, data
// - command bytes captured on clock transitions
// - strobe shows refresh latency during command
// - host limits length, honours extra latency
// - read strobe toggles with each byte
// - strobe high masks write byte, low writes
// - host centres write data, may mask
// - pointer advances one word per cycle
// - burst type taken from each command
// - wrapped burst wraps within aligned group
// - hybrid: one wrap group then linear
// - linear burst runs until select rises
// - linear address wraps within its die
// - refresh only outside data transfers
// - 64M bytes over two 256Mbit dies
// - host selects with clock idle low
// - command sent most significant byte first
// - bus reset low: standby, pins released
module psram_device
  import psram_pkg::*;
(
  // system
  input  wire logic               clk,
  input  wire logic               reset,
  // link
  psram_link_if.dev               link,
  // burst configuration
  input  wire wrap_sel_t          wrap_sel,
  input  wire logic               hybrid_en,
  // core array port
  output logic [WORD_AW-1:0]      core_addr,
  output logic                    core_re,
  output logic                    core_we,
  output logic [1:0]              core_be,
  output logic [15:0]             core_wdata,
  output logic                    core_refresh,
  input  wire logic [15:0]        core_rdata
);
  dev_state_t         st_q;
  logic [7:0]         cnt_q;
  logic [7:0]         lat_q;
  logic [39:0]        ca_q;
  logic               rd_q;
  logic               lin_q;
  logic               hyb_q;
  wrap_sel_t          wrap_q;
  logic [WORD_AW-1:0] start_q;
  logic [WORD_AW-1:0] cur_q;
  logic [5:0]         words_q;
  logic               odd_q;
  logic               ck_prev_q;
  logic               pend_q;
  logic [15:0]        ref_cnt_q;
  logic [15:0]        rd_word_q;
  logic [7:0]         hi_q;
  logic               mhi_q;
  logic [7:0]         dq_q;
  logic               dq_oe_q;
  logic               stb_q;
  logic               stb_oe_q;

  // framing decode; deselect or bus reset sends the block back to idle
  // bus reset gates all
  wire active   = !link.select_n && link.bus_reset_n;
  wire edge_w   = active && (link.bus_clk != ck_prev_q);
  wire ca_done  = (st_q == D_CA) && edge_w && (cnt_q == 8'(CA_BYTES - 1));
  wire lat_done = (st_q == D_LAT) && edge_w && (cnt_q == lat_q - 8'h01);
  wire dat_edge = (st_q == D_DATA) && edge_w;
  wire step     = dat_edge && odd_q;
  wire fetch    = rd_q && (lat_done || step);
  wire store    = !rd_q && step;

  wire [47:0]         ca_w    = {ca_q, link.dq};
  wire [WORD_AW-1:0]  ca_addr = {ca_w[CA_ROW_LSB+ROW_W-1:CA_ROW_LSB], ca_w[COL_W-1:0]};

  // next word address for each burst kind
  // group mask from size
  wire [5:0]          grp_m   = 6'((7'h08 << wrap_q) - 7'h01);
  wire [5:0]          lo_inc  = cur_q[5:0] + 6'h01;
  wire [WORD_AW-1:0]  wrap_nx = {cur_q[WORD_AW-1:6], (cur_q[5:0] & ~grp_m) | (lo_inc & grp_m)};
  wire [DIE_AW-1:0]   lin_lo  = cur_q[DIE_AW-1:0] + 24'h000001;
  wire [DIE_AW-1:0]   hyb_lo  = (start_q[DIE_AW-1:0] | {18'h00000, grp_m}) + 24'h000001;
  wire                hyb_sw  = !lin_q && hyb_q && (words_q == grp_m);
  wire [WORD_AW-1:0]  nxt_w   = lin_q  ? {cur_q[WORD_AW-1], lin_lo} :
                                hyb_sw ? {start_q[WORD_AW-1], hyb_lo} : wrap_nx;

  // refresh: timer sets pending, idle or a long latency services it
  // refresh outside transfers
  wire ref_tick = (ref_cnt_q == 16'(REFRESH_CYCLES - 1));
  wire ref_go   = pend_q && ((st_q == D_IDLE && link.select_n) ||
                             (st_q == D_LAT && lat_q != LAT_EDGES));

  // link pin drivers come straight from flops
  assign link.dq_d        = dq_q;
  assign link.dq_d_oe     = dq_oe_q;
  assign link.strobe_d    = stb_q;
  assign link.strobe_d_oe = stb_oe_q;

  // refresh timer and pending flag; a new tick beats the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_cnt_q    <= 16'h0000;
      pend_q       <= 1'b0;
      core_refresh <= 1'b0;
    end else begin
      ref_cnt_q    <= ref_tick ? 16'h0000 : ref_cnt_q + 16'h0001;
      pend_q       <= ref_tick | (pend_q & !ref_go);
      core_refresh <= ref_go;
    end
  end

  // transaction state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q      <= D_IDLE;
      cnt_q     <= 8'h00;
      ck_prev_q <= BUSCLK_RST;
    end else begin
      ck_prev_q <= link.bus_clk;
      if (!active) begin
        st_q  <= D_IDLE;
        cnt_q <= 8'h00;
      end else begin
        case (st_q)
          D_IDLE: st_q <= D_CA;
          D_CA: if (ca_done) begin
            st_q  <= D_LAT;
            cnt_q <= 8'h00;
          end else if (edge_w) begin
            cnt_q <= cnt_q + 8'h01;
          end
          D_LAT: if (lat_done) begin
            st_q <= D_DATA;
          end else if (edge_w) begin
            cnt_q <= cnt_q + 8'h01;
          end
          D_DATA: st_q <= D_DATA;
          default: st_q <= D_IDLE;
        endcase
      end
    end
  end

  // command capture and burst pointer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ca_q    <= 40'h0000000000;
      rd_q    <= 1'b0;
      lin_q   <= 1'b0;
      hyb_q   <= 1'b0;
      wrap_q  <= WRAP_16B;
      lat_q   <= LAT_EDGES;
      start_q <= '0;
      cur_q   <= '0;
      words_q <= 6'h00;
      odd_q   <= 1'b0;
    end else if (st_q == D_CA && edge_w) begin
      ca_q <= ca_w[39:0];
      if (ca_done) begin
        rd_q    <= ca_w[CA_RD_BIT];
        lin_q   <= ca_w[CA_LIN_BIT];
        hyb_q   <= hybrid_en;
        wrap_q  <= wrap_sel;
        lat_q   <= stb_q ? 8'(2 * LAT_EDGES) : LAT_EDGES;
        start_q <= ca_addr;
        cur_q   <= ca_addr;
        words_q <= 6'h00;
        odd_q   <= 1'b0;
      end
    end else if (dat_edge) begin
      odd_q <= !odd_q;
      if (step) begin
        cur_q   <= nxt_w;
        words_q <= words_q + 6'h01;
        if (hyb_sw) begin
          lin_q <= 1'b1;
        end
      end
    end
  end

  // core port: read fetch ahead of the strobe, write per whole word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_addr  <= '0;
      core_re    <= 1'b0;
      core_we    <= 1'b0;
      core_be    <= 2'h0;
      core_wdata <= 16'h0000;
      hi_q       <= 8'h00;
      mhi_q      <= 1'b1;
    end else begin
      core_re <= fetch;
      core_we <= store;
      if (fetch) begin
        core_addr <= lat_done ? cur_q : nxt_w;
      end else if (store) begin
        core_addr <= cur_q;
      end
      if (dat_edge && !odd_q) begin
        hi_q  <= link.dq;
        mhi_q <= link.strobe_mask_line;
      end
      if (store) begin
        core_wdata <= {hi_q, link.dq};
        core_be    <= {!mhi_q, !link.strobe_mask_line};
      end
    end
  end

  // pin drive: strobe in command phase, strobe and data on reads
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dq_q      <= 8'h00;
      dq_oe_q   <= 1'b0;
      stb_q     <= 1'b0;
      stb_oe_q  <= 1'b0;
      rd_word_q <= 16'h0000;
    end else if (!active) begin
      dq_oe_q  <= 1'b0;
      stb_oe_q <= 1'b0;
      stb_q    <= 1'b0;
    end else if (st_q == D_IDLE) begin
      stb_q    <= pend_q;
      stb_oe_q <= 1'b1;
    end else if (ca_done) begin
      stb_q    <= 1'b0;
      stb_oe_q <= ca_w[CA_RD_BIT];
    end else if (lat_done) begin
      dq_oe_q <= rd_q;
    end else if (dat_edge && rd_q) begin
      stb_q <= !stb_q;
      if (odd_q) begin
        dq_q <= rd_word_q[7:0];
      end else begin
        dq_q      <= core_rdata[15:8];
        rd_word_q <= core_rdata;
      end
    end
  end
endmodule

// file: rtl/psram_pkg.sv
// Purpose: shared constants and types for the ddr psram link
// Assumes: one 125 MHz system clock on both ends
// Notes:   one bus clock edge carries one byte; one bus cycle one word
package psram_pkg;
  // system clock and refresh timing
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int REFRESH_NS     = 4000;
  localparam int REFRESH_CYCLES = (REFRESH_NS * 1000) / CLK_PERIOD_PS;
  // command-address framing
  localparam int CA_BYTES   = 6;
  localparam int CA_RD_BIT  = 47;
  localparam int CA_LIN_BIT = 45;
  localparam int CA_ROW_LSB = 16;
  localparam int ROW_W      = 22;
  localparam int COL_W      = 3;
  // initial latency in bus clock cycles, doubled when refresh is pending
  localparam int LAT_CLOCKS = 6;
  localparam logic [7:0] LAT_EDGES = 8'(2 * LAT_CLOCKS);
  // host wait after its last bus edge before releasing select
  localparam logic [1:0] END_WAIT = 2'h3;
  // array: 2 dies x 16M words x 16 bits = 64M bytes
  localparam int WORD_AW = 25;
  localparam int DIE_AW  = 24;
  // reset levels of the link pins
  localparam logic SELECT_N_RST = 1'b1;
  localparam logic BUSCLK_RST   = 1'b0;

  typedef enum logic [1:0] {
    WRAP_16B  = 2'h0,
    WRAP_32B  = 2'h1,
    WRAP_64B  = 2'h2,
    WRAP_128B = 2'h3
  } wrap_sel_t;

  typedef enum logic [3:0] {
    D_IDLE = 4'h1,
    D_CA   = 4'h2,
    D_LAT  = 4'h4,
    D_DATA = 4'h8
  } dev_state_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_CA   = 5'h02,
    H_LAT  = 5'h04,
    H_DATA = 5'h08,
    H_END  = 5'h10
  } host_state_t;
endpackage

// file: rtl/psram_link_if.sv
// Purpose: ddr psram link between host and device ends
// Assumes: both ends clocked by the same system clock
// Notes:   two-way pins resolve here; an undriven pin reads low
`timescale 1ns/1ps
interface psram_link_if;
  // host driven pins
  logic       select_n;
  logic       bus_clk;
  logic       clock_complement;
  logic       bus_reset_n;
  // two-way pins, one driver and enable per end
  logic [7:0] dq_h;
  logic       dq_h_oe;
  logic [7:0] dq_d;
  logic       dq_d_oe;
  logic       strobe_h;
  logic       strobe_h_oe;
  logic       strobe_d;
  logic       strobe_d_oe;
  // resolved wire levels
  logic [7:0] dq;
  logic       strobe_mask_line;

  // device wins a clash so a host bug cannot hide read data
  assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'h00);
  assign strobe_mask_line = strobe_d_oe ? strobe_d : (strobe_h_oe ? strobe_h : 1'b0);

  modport host (
    output select_n, bus_clk, clock_complement, bus_reset_n,
    output dq_h, dq_h_oe, strobe_h, strobe_h_oe,
    input  dq, strobe_mask_line
  );
  modport dev (
    input  select_n, bus_clk, clock_complement, bus_reset_n,
    output dq_d, dq_d_oe, strobe_d, strobe_d_oe,
    input  dq, strobe_mask_line
  );
endinterface

// file: rtl/psram_host.sv
// Purpose: host end of the ddr psram link, one burst per start pulse
// Assumes: device answers one system clock after each bus edge
// Notes:   bus clock toggles every second system clock
`timescale 1ns/1ps
module psram_host
  import psram_pkg::*;
(
  // system
  input  wire logic               clk,
  input  wire logic               reset,
  // command
  input  wire logic               start,
  input  wire logic               cmd_read,
  input  wire logic               cmd_linear,
  input  wire logic [WORD_AW-1:0] cmd_addr,
  input  wire logic [7:0]         cmd_len,
  output logic                    busy,
  // write words
  input  wire logic [15:0]        wr_data,
  input  wire logic [1:0]         wr_mask,
  output logic                    wr_take,
  // read words
  output logic [15:0]             rd_data,
  output logic                    rd_valid,
  // link
  psram_link_if.host              link
);
  host_state_t st_q;
  logic        ph_q;
  logic [8:0]  ecnt_q;
  logic [8:0]  last_q;
  logic [7:0]  lat_q;
  logic [47:0] ca_q;
  logic        rd_q;
  logic [1:0]  wait_q;
  logic        sel_n_q;
  logic        ck_q;
  logic        rst_n_q;
  logic [7:0]  dq_q;
  logic        dq_oe_q;
  logic        stb_q;
  logic        stb_oe_q;
  logic        stb_prev_q;
  logic        bt_q;
  logic [7:0]  rd_hi_q;

  // divider: set phase drives bytes, toggle phase moves the clock
  wire toggle  = ph_q && (st_q == H_CA || st_q == H_LAT || st_q == H_DATA);
  wire setph   = !ph_q && (st_q == H_CA || st_q == H_DATA);
  wire odd_w   = ecnt_q[0];
  wire dat_end = (st_q == H_DATA) && toggle && (ecnt_q == last_q);
  wire stb_chg = rd_q && (st_q == H_DATA || st_q == H_END) &&
                 (link.strobe_mask_line != stb_prev_q);

  assign link.select_n         = sel_n_q;
  assign link.bus_clk          = ck_q;
  assign link.clock_complement = !ck_q;
  assign link.bus_reset_n      = rst_n_q;
  assign link.dq_h             = dq_q;
  assign link.dq_h_oe          = dq_oe_q;
  assign link.strobe_h         = stb_q;
  assign link.strobe_h_oe      = stb_oe_q;

  // sequencing and link pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= H_IDLE;
      ph_q <= 1'b0;
      ecnt_q <= 9'h000;
      last_q <= 9'h001;
      lat_q <= LAT_EDGES;
      ca_q <= 48'h000000000000;
      rd_q <= 1'b0;
      wait_q <= 2'h0;
      sel_n_q <= SELECT_N_RST;
      ck_q <= BUSCLK_RST;
      rst_n_q <= 1'b0;
      dq_q <= 8'h00;
      dq_oe_q <= 1'b0;
      stb_q <= 1'b0;
      stb_oe_q <= 1'b0;
      busy <= 1'b0;
      wr_take <= 1'b0;
    end else begin
      rst_n_q <= 1'b1;
      ph_q    <= (st_q == H_IDLE) ? 1'b0 : !ph_q;
      wr_take <= setph && (st_q == H_DATA) && !rd_q && odd_w;
      if (toggle) begin
        ck_q   <= !ck_q;
        ecnt_q <= ecnt_q + 9'h001;
      end
      case (st_q)
        H_IDLE: if (start && rst_n_q) begin
          st_q    <= H_CA;
          busy    <= 1'b1;
          sel_n_q <= 1'b0;
          ecnt_q  <= 9'h000;
          rd_q    <= cmd_read;
          last_q  <= {cmd_len, 1'b0} - 9'h001;
          ca_q    <= {cmd_read, 1'b0, cmd_linear, 7'h00, cmd_addr[WORD_AW-1:COL_W],
                      13'h0000, cmd_addr[COL_W-1:0]};
        end
        H_CA: begin
          if (setph) begin
            dq_q    <= ca_q[47:40];
            dq_oe_q <= 1'b1;
            ca_q    <= {ca_q[39:0], 8'h00};
          end
          if (toggle && ecnt_q == 9'h000) begin
            lat_q <= link.strobe_mask_line ? 8'(2 * LAT_EDGES) : LAT_EDGES;
          end
          if (toggle && ecnt_q == 9'(CA_BYTES - 1)) begin
            st_q   <= H_LAT;
            ecnt_q <= 9'h000;
          end
        end
        // the device samples a clk after each edge, so the last byte stays driven
        // hold last byte
        H_LAT: begin
          dq_oe_q <= 1'b0;
          if (toggle && ecnt_q == {1'b0, lat_q} - 9'h001) begin
            st_q   <= H_DATA;
            ecnt_q <= 9'h000;
          end
        end
        H_DATA: begin
          // bytes set a quarter period early
          if (setph && !rd_q) begin
            dq_q     <= odd_w ? wr_data[7:0] : wr_data[15:8];
            stb_q    <= odd_w ? wr_mask[0] : wr_mask[1];
            dq_oe_q  <= 1'b1;
            stb_oe_q <= 1'b1;
          end
          if (dat_end) begin
            st_q   <= H_END;
            wait_q <= 2'h0;
          end
        end
        H_END: begin
          wait_q <= wait_q + 2'h1;
          if (wait_q == END_WAIT) begin
            st_q     <= H_IDLE;
            sel_n_q  <= 1'b1;
            dq_oe_q  <= 1'b0;
            stb_oe_q <= 1'b0;
            busy     <= 1'b0;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // read capture on every strobe change, high byte first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stb_prev_q <= 1'b0;
      bt_q       <= 1'b0;
      rd_hi_q    <= 8'h00;
      rd_data    <= 16'h0000;
      rd_valid   <= 1'b0;
    end else begin
      stb_prev_q <= link.strobe_mask_line;
      rd_valid   <= stb_chg && bt_q;
      if (st_q == H_IDLE) begin
        bt_q <= 1'b0;
      end else if (stb_chg) begin
        bt_q <= !bt_q;
        if (bt_q) begin
          rd_data <= {rd_hi_q, link.dq};
        end else begin
          rd_hi_q <= link.dq;
        end
      end
    end
  end
endmodule

// file: bench/psram_link_properties.sv
// Purpose: concurrent checks on the psram link pins and device core strobes
// Assumes: one system clock; reset asynchronous, active high
// Notes:   bus edges are found as the device finds them, by last sample
`timescale 1ns/1ps
module psram_link_properties (
  // system
  input wire logic       clk,
  input wire logic       reset,
  // link pins
  input wire logic       select_n,
  input wire logic       bus_clk,
  input wire logic       clock_complement,
  input wire logic [7:0] dq,
  input wire logic       dq_h_oe,
  input wire logic       dq_d_oe,
  input wire logic       strobe_mask_line,
  input wire logic       strobe_d_oe,
  // device core strobes
  input wire logic       core_re,
  input wire logic       core_we,
  input wire logic       core_refresh
);
  logic [7:0] edges_q;
  logic       bclk_q;
  logic       rd_q;
  logic       moved_q;
  wire        bus_edge;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // an edge is a change against the last sample
  assign bus_edge = bus_clk != bclk_q;

  // edge count and read bit of the open transaction; cleared on deselect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edges_q <= 8'h00;
      bclk_q  <= 1'b0;
      rd_q    <= 1'b0;
      moved_q <= 1'b0;
    end else begin
      bclk_q <= bus_clk;
      if (select_n) begin
        edges_q <= 8'h00;
        rd_q    <= 1'b0;
        moved_q <= 1'b0;
      end else begin
        if (bus_edge) edges_q <= edges_q + 8'h01;
        if (bus_edge && edges_q == 8'h00) rd_q <= dq[7];
        if (core_re || core_we) moved_q <= 1'b1;
      end
    end
  end

  sequence open_s;
    $fell(select_n);
  endsequence
  sequence ca_phase_s;
    !select_n && !$past(select_n) && edges_q < 8'h06;
  endsequence

  clk_idle_a: assert property (open_s |-> !bus_clk && clock_complement)
    else $error("bus clock not idle at select");
  clk_pair_a: assert property (clock_complement != bus_clk)
    else $error("clock complement equals clock");
  strobe_open_a: assert property (open_s |=> strobe_d_oe)
    else $error("no latency flag after select");
  ca_drive_a: assert property (ca_phase_s |-> strobe_d_oe && dq_h_oe && !dq_d_oe)
    else $error("wrong drivers in command phase");
  host_hold_a: assert property (
      !select_n && dq_h_oe && $changed(bus_clk) |-> $stable(dq))
    else $error("host byte moved on its clock edge");
  clock_pace_a: assert property (!select_n && $changed(bus_clk) |=> $stable(bus_clk))
    else $error("bus clock edges too close");
  write_dir_a: assert property (!select_n && !rd_q && edges_q > 8'h00 |-> !dq_d_oe)
    else $error("device drives data in a write");
  read_strobe_a: assert property (
      dq_d_oe && $past(dq_d_oe) && $changed(dq) |-> $changed(strobe_mask_line))
    else $error("read byte changed without strobe");
  strobe_edge_a: assert property (
      dq_d_oe && $past(dq_d_oe) && $changed(strobe_mask_line)
      |-> $past(bus_clk) != $past(bus_clk, 2))
    else $error("read strobe moved without bus edge");
  release_a: assert property (select_n && $past(select_n) |-> !dq_d_oe && !strobe_d_oe)
    else $error("pins driven while deselected");
  word_pace_a: assert property (core_we |=> !core_we [*3])
    else $error("core writes closer than one bus cycle");
  refresh_idle_a: assert property (core_refresh |-> !moved_q && !core_re && !core_we)
    else $error("refresh during data transfer");
endmodule

// file: bench/tb_top.sv
// Purpose: self-checking bench joining host and device ends of the link
// Assumes: core array modelled here, read data one clk after core_re
// Notes:   reference memory and word order worked out from the burst rules
`timescale 1ns/1ps
module tb_top
  import psram_pkg::*;
();
  logic                clk, reset, start, cmd_read, cmd_linear, busy;
  logic                wr_take, rd_valid, hybrid_en, tk;
  logic                core_re, core_we, core_refresh;
  logic [WORD_AW-1:0]  cmd_addr, core_addr, a;
  logic [7:0]          cmd_len;
  logic [15:0]         wr_data, rd_data, core_wdata, core_rdata;
  logic [1:0]          wr_mask, core_be;
  wrap_sel_t           wrap_sel;
  logic [31:0]         r, q;
  int                  mismatches, total_checks, nref, widx;
  int unsigned         seed;
  logic [15:0]         mem [logic [WORD_AW-1:0]];
  logic [15:0]         model [logic [WORD_AW-1:0]];
  logic [15:0]         wd [$];
  logic [1:0]          wm [$];
  logic [15:0]         exq [$];

  psram_link_if link ();

  psram_host i_psram_host (
    .clk(clk), .reset(reset), .start(start), .cmd_read(cmd_read),
    .cmd_linear(cmd_linear), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .busy(busy),
    .wr_data(wr_data), .wr_mask(wr_mask), .wr_take(wr_take), .rd_data(rd_data),
    .rd_valid(rd_valid), .link(link)
  );
  psram_device i_psram_device (
    .clk(clk), .reset(reset), .link(link), .wrap_sel(wrap_sel), .hybrid_en(hybrid_en),
    .core_addr(core_addr), .core_re(core_re), .core_we(core_we), .core_be(core_be),
    .core_wdata(core_wdata), .core_refresh(core_refresh), .core_rdata(core_rdata)
  );
  psram_link_properties i_psram_link_properties (
    .clk(clk), .reset(reset), .select_n(link.select_n), .bus_clk(link.bus_clk),
    .clock_complement(link.clock_complement), .dq(link.dq), .dq_h_oe(link.dq_h_oe),
    .dq_d_oe(link.dq_d_oe), .strobe_mask_line(link.strobe_mask_line),
    .strobe_d_oe(link.strobe_d_oe), .core_re(core_re), .core_we(core_we),
    .core_refresh(core_refresh)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic fail(string msg);
    mismatches++;
    $display("CHECK FAILED at %0t ns: %s", $time, msg);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d refreshes %0d", total_checks, mismatches, nref);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // word address of beat i; linear and hybrid tails stay inside the die
  function automatic logic [WORD_AW-1:0] waddr(logic [WORD_AW-1:0] st, bit lin, bit hyb,
                                               int w, int i);
    logic [WORD_AW-1:0] base;
    base = st & ~(WORD_AW'(w - 1));
    if (lin) return {st[24], 24'(st[23:0] + i)};
    if (hyb && i >= w) return {st[24], 24'(base[23:0] + i)};
    return base + WORD_AW'((int'(st - base) + i) % w);
  endfunction

  // core array; untouched words read unknown so a stray address shows up
  always @(posedge clk) begin
    if (core_we === 1'b1 && core_be[1]) mem[core_addr][15:8] = core_wdata[15:8];
    if (core_we === 1'b1 && core_be[0]) mem[core_addr][7:0] = core_wdata[7:0];
    if (reset) begin
      core_rdata <= 16'h0000;
    end else if (core_re === 1'b1) begin
      core_rdata <= #1 mem.exists(core_addr) ? mem[core_addr] : 16'hXXXX;
    end
    if (core_refresh === 1'b1) nref++;
    if (rd_valid === 1'b1) begin
      total_checks++;
      if (exq.size() == 0) fail("read word not expected");
      else if (rd_data !== exq.pop_front()) begin
        fail("read word differs");
      end
    end
  end

  // write words advance one per take, presented one delay after the edge
  always @(posedge clk) begin
    tk = wr_take;
    #1;
    if (tk === 1'b1) widx++;
    if (widx < wd.size()) begin
      wr_data = wd[widx];
      wr_mask = wm[widx];
    end else begin
      wr_data = 16'h0000;
      wr_mask = 2'h0;
    end
  end

  // one burst: model updated first, then started and waited out
  task automatic burst(bit rd, bit lin, bit hyb, logic [1:0] ws, logic [WORD_AW-1:0] st,
                       int len);
    int                 n;
    logic [WORD_AW-1:0] ad;
    logic [31:0]        rv;
    wd.delete();
    wm.delete();
    for (int i = 0; i < len; i++) begin
      ad = waddr(st, lin, hyb, 8 << ws, i);
      rv = rnd();
      if (!model.exists(ad)) begin
        model[ad] = 16'(ad) ^ 16'hA5C3;
        mem[ad] = model[ad];
      end
      if (rd) begin
        exq.push_back(model[ad]);
      end else begin
        wd.push_back(rv[15:0]);
        wm.push_back(rv[17:16]);
        if (!rv[17]) model[ad][15:8] = rv[15:8];
        if (!rv[16]) model[ad][7:0] = rv[7:0];
      end
    end
    widx = 0;
    @(posedge clk);
    #1;
    cmd_read = rd;
    cmd_linear = lin;
    hybrid_en = hyb;
    wrap_sel = wrap_sel_t'(ws);
    cmd_addr = st;
    cmd_len = 8'(len);
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    total_checks++;
    if (n >= 4000 || exq.size() != 0 || (!rd && widx != len)) begin
      fail("burst incomplete");
    end
  endtask

  initial begin
    seed = 43;
    reset = 1'b1;
    {start, cmd_read, cmd_linear, hybrid_en} = '0;
    cmd_addr = '0;
    cmd_len = 8'h01;
    wrap_sel = WRAP_16B;
    repeat (10) @(posedge clk);
    total_checks++;
    if (link.dq_d_oe !== 1'b0 || link.strobe_d_oe !== 1'b0) fail("pins driven in reset");
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    // linear bursts over the top of each die come back to its own base
    burst(0, 1, 0, 2'h0, 25'h0FFFFFC, 8);
    burst(1, 1, 0, 2'h0, 25'h0000000, 4);
    burst(1, 1, 0, 2'h0, 25'h1000000, 2);
    burst(0, 1, 0, 2'h0, 25'h1FFFFFE, 4);
    burst(1, 1, 0, 2'h0, 25'h1FFFFFE, 4);
    // every group size: wrap once round past the start, hybrid tail, then a linear view
    for (int s = 0; s < 4; s++) begin
      burst(0, 0, 0, 2'(s), 25'h0000203, (8 << s) + 2);
      burst(1, 0, 1, 2'(s), 25'h0000205, (8 << s) + 4);
      burst(1, 1, 0, 2'(s), 25'h0000200, 8 << s);
    end
    // random mix of types and sizes, back to back, long enough to meet refresh
    for (int k = 0; k < 30; k++) begin
      r = rnd();
      q = rnd();
      a = 25'(r & 32'h010007FF);
      burst(0, q[0], q[1], q[3:2], a, 1 + int'(q[10:4]) % 90);
      burst(1, q[11], q[12], q[14:13], a, 1 + int'(q[21:15]) % 90);
    end
    total_checks++;
    if (nref == 0) fail("no hidden refresh seen");
    report_and_stop();
  end

  // the whole sequence needs well under this many cycles
  initial begin
    repeat (60000) @(posedge clk);
    fail("run timed out");
    report_and_stop();
  end
endmodule
